// ===== src/rocof_pkg.sv
package rocof_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 100_000_000;
   localparam int CYCLE_US = 5000;
   localparam int CYCLE_CLKS_DEF = CYCLE_US * (CLK_HZ / 1_000_000);
   localparam int PRE_TRIG_US = 20000;
   localparam int PRE_CYC = PRE_TRIG_US / CYCLE_US;

   // ----------------------------------------------------------------
   // scaling (rate in 10 mHz/s, freq in 10 mHz)
   // ----------------------------------------------------------------
   localparam int RATE_STEP_MHZS = 10;
   localparam int HYST_MHZS = 100;
   localparam logic [16:0] HYST_STEPS = 17'(HYST_MHZS / RATE_STEP_MHZS);
   localparam int MAX_STEP_MHZS = 100;
   localparam logic [4:0] MAX_SCALE = 5'(MAX_STEP_MHZS / RATE_STEP_MHZS);
   localparam int RATIO_STEP_MPU = 5;
   localparam int RATIO_SCALE = 1000 / RATIO_STEP_MPU;
   localparam int NUM_GROUPS = 8;
   localparam int REC_DEPTH = 12;

   // ----------------------------------------------------------------
   // register offsets and fields
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_MAXRATE = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_RATE = 8'h0C;
   localparam logic [7:0] REG_RATIO = 8'h10;
   localparam logic [7:0] REG_EXPTIME = 8'h14;
   localparam logic [7:0] REG_REMAIN = 8'h18;
   localparam logic [7:0] REG_COUNT = 8'h1C;
   localparam logic [7:0] REG_RECSEL = 8'h20;
   localparam logic [7:0] REG_REC_TIME = 8'h24;
   localparam logic [7:0] REG_REC_INFO = 8'h28;
   localparam logic [7:0] REG_REC_PRE = 8'h2C;
   localparam logic [7:0] REG_REC_FLT = 8'h30;
   localparam logic [1:0] GF_CFG = 2'h0;
   localparam logic [1:0] GF_PICK = 2'h1;
   localparam logic [1:0] GF_FLIM = 2'h2;
   localparam logic [1:0] GF_DELAY = 2'h3;
   localparam int CTRL_EN = 0;
   localparam int CTRL_MASK_ON = 1;
   localparam int CTRL_MASK_OFF = 2;
   localparam int CTRL_CNT_CLR = 3;
   localparam int GCFG_USED = 0;
   localparam int GCFG_LIM = 3;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] PICK_RST = 16'h0014;
   localparam logic [15:0] FLOW_RST = 16'h1383;
   localparam logic [15:0] FHIGH_RST = 16'h13EC;
   localparam logic [15:0] MAXRATE_RST = 16'h00C8;
   localparam logic [15:0] DELAY_RST = 16'h0014;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {MODE_RISE, MODE_FALL, MODE_BOTH} mode_t;
   typedef enum logic [1:0] {ST_NORMAL, ST_START, ST_TRIP, ST_BLOCKED} status_t;
   typedef struct packed {
      logic used;
      mode_t mode;
      logic limUse;
      logic [15:0] pick;
      logic [15:0] fLow;
      logic [15:0] fHigh;
      logic [15:0] delay;
   } grp_cfg_t;
   typedef struct packed {
      logic signed [15:0] rate;
      logic [15:0] freq;
   } meas_t;
   typedef struct packed {
      logic [31:0] stamp;
      logic isTrip;
      logic [2:0] grp;
      meas_t pre;
      meas_t flt;
   } fault_rec_t;
   typedef struct packed {
      logic [5:0] flags;
      logic [31:0] stamp;
   } evt_t;

endpackage

// ===== src/rocof_stage.sv
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps

// Contract
// - ratio of measured rate to pick-up
// - release only past 100 mHz/s hysteresis
// - rising, falling or both direction modes
// - frequency limits used or not
// - falling trips only below low limit
// - rising trips only above high limit
// - stage runs only in participating groups
// - group change applies at program cycle start
// - definite delay starts at unblocked pick-up
// - live rate, status, ratio, operating time
// - remaining time while counting to trip
// - block sampled at program cycle start
// - unblocked pick-up gives start, timing
// - blocked pick-up gives blocked only
// - late block drops start, releases
// - masked time-stamped on/off events
// - resettable counter of start/trip/blocked
// - twelve most recent fault records kept
// - record time, event, pre and fault values
// - start, trip, blocked outputs exported
// - over maximum rate blocks function
// - disabled stage gives no outputs
module rocof_stage
   import rocof_pkg::*;
#(
   parameter int CYCLE_CLKS = CYCLE_CLKS_DEF
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // frequency tracking and blocking matrix
   input wire meas_t meas,
   input wire logic blockIn,
   input wire logic [2:0] groupSel,
   input wire logic [31:0] timeNow,
   // register port
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdData,
   // stage outputs
   output logic startOut,
   output logic tripOut,
   output logic blockedOut,
   output evt_t evt
);

   localparam int TW = $clog2(CYCLE_CLKS);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [TW-1:0] tickCnt_r;
   logic tick_r;
   logic evalTick_r;
   logic blkS_r;
   meas_t meas_r;
   logic [2:0] grp_r;
   meas_t hist_r [PRE_CYC];
   grp_cfg_t grpCfg_r [NUM_GROUPS];
   grp_cfg_t cfg;
   logic en_r;
   logic maskOn_r;
   logic maskOff_r;
   logic [15:0] maxRate_r;
   status_t state_r;
   status_t state_nxt;
   logic [15:0] elapsed_r;
   logic [15:0] elapsed_nxt;
   logic [15:0] ratio_r;
   logic [15:0] count_r;
   logic [3:0] recSel_r;
   logic [3:0] wrPtr_r;
   fault_rec_t rec_r [REC_DEPTH];
   fault_rec_t recRd;
   logic [16:0] absMag;
   logic [16:0] dirMag;
   logic pickUp;
   logic holdPick;
   logic permit;
   logic overMax;
   logic blkEff;
   logic stageOn;
   logic cntClr;
   logic [2:0] flagNxt;
   logic [2:0] flagCur;
   logic [5:0] rawEvt;
   logic anyOn;

   function automatic logic [15:0] ratio_of(input logic [16:0] m, input logic [15:0] p);
      logic [33:0] q;
      q = (34'(m) * 34'(RATIO_SCALE)) / 34'((p == 16'h0000) ? 16'h0001 : p);
      return (q > 34'h0FFFF) ? 16'hFFFF : q[15:0];
   endfunction

   // ----------------------------------------------------------------
   // program cycle time base and input sampling
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tickCnt_r <= '0;
         tick_r <= 1'b0;
      end
      else if (tickCnt_r == TW'(CYCLE_CLKS - 1))
      begin
         tickCnt_r <= '0;
         tick_r <= 1'b1;
      end
      else
      begin
         tickCnt_r <= tickCnt_r + 1'b1;
         tick_r <= 1'b0;
      end
   end

   // block, measurement and group caught first, evaluated next clock
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         blkS_r <= 1'b0;
         meas_r <= '0;
         grp_r <= 3'h0;
         evalTick_r <= 1'b0;
         for (int i = 0; i < PRE_CYC; i++)
            hist_r[i] <= '0;
      end
      else
      begin
         evalTick_r <= tick_r;
         if (tick_r)
         begin
            blkS_r <= blockIn;
            meas_r <= meas;
            grp_r <= groupSel;
            hist_r[0] <= meas_r;
            for (int i = 1; i < PRE_CYC; i++)
               hist_r[i] <= hist_r[i-1];
         end
      end
   end

   // ----------------------------------------------------------------
   // pick-up, permit and state decision
   // ----------------------------------------------------------------
   assign cfg = grpCfg_r[grp_r];

   always_comb
   begin
      absMag = meas_r.rate[15] ? 17'(-18'(meas_r.rate)) : 17'(meas_r.rate);
      case (cfg.mode)
         MODE_RISE: dirMag = meas_r.rate[15] ? 17'h00000 : absMag;
         MODE_FALL: dirMag = meas_r.rate[15] ? absMag : 17'h00000;
         default: dirMag = absMag;
      endcase
      pickUp = dirMag >= 17'(cfg.pick);
      holdPick = (dirMag + HYST_STEPS) > 17'(cfg.pick);
      if (!cfg.limUse)
         permit = 1'b1;
      else if (meas_r.rate[15])
         permit = meas_r.freq < cfg.fLow;
      else
         permit = meas_r.freq > cfg.fHigh;
      overMax = absMag > 17'(maxRate_r) * 17'(MAX_SCALE);
      blkEff = blkS_r || overMax;
      stageOn = en_r && cfg.used;
      state_nxt = state_r;
      elapsed_nxt = elapsed_r;
      if (!stageOn)
         state_nxt = ST_NORMAL;
      else if (evalTick_r)
      begin
         case (state_r)
            ST_NORMAL:
               if (pickUp)
               begin
                  state_nxt = blkEff ? ST_BLOCKED : ST_START;
                  elapsed_nxt = 16'h0000;
               end
            ST_START:
               if (blkEff || !holdPick)
                  state_nxt = ST_NORMAL;
               else if (permit && elapsed_r >= cfg.delay)
                  state_nxt = ST_TRIP;
               else if (permit)
                  elapsed_nxt = elapsed_r + 16'h0001;
            ST_TRIP:
               if (blkEff || !holdPick)
                  state_nxt = ST_NORMAL;
            ST_BLOCKED:
               if (!blkEff || !holdPick)
                  state_nxt = ST_NORMAL;
            default:
               state_nxt = ST_NORMAL;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r <= ST_NORMAL;
         elapsed_r <= 16'h0000;
      end
      else
      begin
         state_r <= state_nxt;
         elapsed_r <= elapsed_nxt;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         ratio_r <= 16'h0000;
      else if (evalTick_r)
         ratio_r <= ratio_of(absMag, cfg.pick);
   end

   // ----------------------------------------------------------------
   // outputs and events
   // ----------------------------------------------------------------
   assign flagNxt = {state_nxt == ST_BLOCKED, state_nxt == ST_TRIP,
      state_nxt == ST_START || state_nxt == ST_TRIP};
   assign flagCur = {blockedOut, tripOut, startOut};
   // on flags in [2:0], off flags in [5:3]
   assign rawEvt = {flagCur & ~flagNxt, flagNxt & ~flagCur};
   assign anyOn = |rawEvt[2:0];
   assign cntClr = regWr && (regAddr == REG_CTRL) && regWrData[CTRL_CNT_CLR];

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         startOut <= 1'b0;
         tripOut <= 1'b0;
         blockedOut <= 1'b0;
         evt <= '0;
      end
      else
      begin
         {blockedOut, tripOut, startOut} <= flagNxt;
         evt.flags <= rawEvt & {{3{maskOff_r}}, {3{maskOn_r}}};
         evt.stamp <= timeNow;
      end
   end

   // a clear in the same clock as a new event leaves the count at one
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         count_r <= 16'h0000;
      else if (anyOn)
         count_r <= cntClr ? 16'h0001 : count_r + 16'h0001;
      else if (cntClr)
         count_r <= 16'h0000;
   end

   // ----------------------------------------------------------------
   // fault record ring
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wrPtr_r <= 4'h0;
         for (int i = 0; i < REC_DEPTH; i++)
            rec_r[i] <= '0;
      end
      else if (rawEvt[0] || rawEvt[1])
      begin
         rec_r[wrPtr_r].stamp <= timeNow;
         rec_r[wrPtr_r].isTrip <= rawEvt[1];
         rec_r[wrPtr_r].grp <= grp_r;
         rec_r[wrPtr_r].pre <= hist_r[PRE_CYC-1];
         rec_r[wrPtr_r].flt <= meas_r;
         wrPtr_r <= (wrPtr_r == 4'(REC_DEPTH - 1)) ? 4'h0 : wrPtr_r + 4'h1;
      end
   end

   assign recRd = (recSel_r < 4'(REC_DEPTH)) ? rec_r[recSel_r] : '0;

   // ----------------------------------------------------------------
   // register port
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         en_r <= 1'b0;
         maskOn_r <= 1'b1;
         maskOff_r <= 1'b1;
         maxRate_r <= MAXRATE_RST;
         recSel_r <= 4'h0;
      end
      else if (regWr && regAddr == REG_CTRL)
      begin
         en_r <= regWrData[CTRL_EN];
         maskOn_r <= regWrData[CTRL_MASK_ON];
         maskOff_r <= regWrData[CTRL_MASK_OFF];
      end
      else if (regWr && regAddr == REG_MAXRATE)
         maxRate_r <= regWrData[15:0];
      else if (regWr && regAddr == REG_RECSEL)
         recSel_r <= regWrData[3:0];
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < NUM_GROUPS; i++)
            grpCfg_r[i] <= '{1'b0, MODE_RISE, 1'b0, PICK_RST, FLOW_RST, FHIGH_RST, DELAY_RST};
      end
      else if (regWr && regAddr[7])
      begin
         case (regAddr[3:2])
            GF_CFG:
            begin
               grpCfg_r[regAddr[6:4]].used <= regWrData[GCFG_USED];
               grpCfg_r[regAddr[6:4]].mode <= mode_t'(regWrData[2:1]);
               grpCfg_r[regAddr[6:4]].limUse <= regWrData[GCFG_LIM];
            end
            GF_PICK: grpCfg_r[regAddr[6:4]].pick <= regWrData[15:0];
            GF_FLIM:
            begin
               grpCfg_r[regAddr[6:4]].fLow <= regWrData[15:0];
               grpCfg_r[regAddr[6:4]].fHigh <= regWrData[31:16];
            end
            default: grpCfg_r[regAddr[6:4]].delay <= regWrData[15:0];
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         regRdData <= 32'h0000_0000;
      else if (!regRd)
         regRdData <= 32'h0000_0000;
      else if (regAddr[7])
         case (regAddr[3:2])
            GF_CFG: regRdData <= {28'h0, grpCfg_r[regAddr[6:4]].limUse,
               grpCfg_r[regAddr[6:4]].mode, grpCfg_r[regAddr[6:4]].used};
            GF_PICK: regRdData <= {16'h0, grpCfg_r[regAddr[6:4]].pick};
            GF_FLIM: regRdData <= {grpCfg_r[regAddr[6:4]].fHigh, grpCfg_r[regAddr[6:4]].fLow};
            default: regRdData <= {16'h0, grpCfg_r[regAddr[6:4]].delay};
         endcase
      else
         case (regAddr)
            REG_CTRL: regRdData <= {29'h0, maskOff_r, maskOn_r, en_r};
            REG_MAXRATE: regRdData <= {16'h0, maxRate_r};
            REG_STATUS: regRdData <= {20'h0, wrPtr_r, 2'b00, grp_r, 1'b0, 2'(state_r)};
            REG_RATE: regRdData <= {{16{meas_r.rate[15]}}, meas_r.rate};
            REG_RATIO: regRdData <= {16'h0, ratio_r};
            REG_EXPTIME: regRdData <= {16'h0, cfg.delay};
            REG_REMAIN: regRdData <= (state_r == ST_START) ?
               {16'h0, cfg.delay - elapsed_r} : 32'h0000_0000;
            REG_COUNT: regRdData <= {16'h0, count_r};
            REG_RECSEL: regRdData <= {28'h0, recSel_r};
            REG_REC_TIME: regRdData <= recRd.stamp;
            REG_REC_INFO: regRdData <= {27'h0, recRd.grp, 1'b0, recRd.isTrip};
            REG_REC_PRE: regRdData <= recRd.pre;
            REG_REC_FLT: regRdData <= recRd.flt;
            default: regRdData <= 32'h0000_0000;
         endcase
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence s_evalNormal;
      evalTick_r && stageOn && state_r == ST_NORMAL && pickUp;
   endsequence

   sequence s_evalStart;
      evalTick_r && stageOn && state_r == ST_START && !blkEff && holdPick;
   endsequence

   property p_sample;
      tick_r |=> blkS_r == $past(blockIn);
   endproperty
   a_sample: assert property (p_sample) else $error("block not sampled at cycle start");

   property p_start;
      s_evalNormal and !blkEff |=> startOut && !tripOut && elapsed_r == 16'h0000;
   endproperty
   a_start: assert property (p_start) else $error("unblocked pick-up gave no start");

   property p_blocked;
      s_evalNormal and blkEff |=> blockedOut && !startOut ##1 !startOut;
   endproperty
   a_blocked: assert property (p_blocked) else $error("blocked pick-up not blocked");

   property p_lateBlock;
      evalTick_r && stageOn && state_r == ST_START && blkS_r |=> !startOut && !blockedOut;
   endproperty
   a_lateBlock: assert property (p_lateBlock) else $error("late block kept start");

   property p_trip;
      s_evalStart and permit && elapsed_r >= cfg.delay |=> tripOut && startOut;
   endproperty
   a_trip: assert property (p_trip) else $error("no trip after delay");

   property p_noPermit;
      s_evalStart and !permit |=> !tripOut && $stable(elapsed_r);
   endproperty
   a_noPermit: assert property (p_noPermit) else $error("trip without frequency permit");

   property p_hold;
      s_evalStart and !pickUp |=> startOut;
   endproperty
   a_hold: assert property (p_hold) else $error("released inside hysteresis");

   property p_disabled;
      !stageOn |=> !startOut && !tripOut && !blockedOut;
   endproperty
   a_disabled: assert property (p_disabled) else $error("disabled stage gave output");

   property p_count;
      anyOn && !cntClr |=> count_r == $past(count_r) + 16'h0001;
   endproperty
   a_count: assert property (p_count) else $error("counter missed an event");

   property p_mask;
      |evt.flags |-> ((|evt.flags[2:0]) -> $past(maskOn_r)) && ((|evt.flags[5:3]) -> $past(maskOff_r));
   endproperty
   a_mask: assert property (p_mask) else $error("masked event emitted");

   property p_maxRate;
      s_evalNormal and overMax |=> blockedOut;
   endproperty
   a_maxRate: assert property (p_maxRate) else $error("over max rate not blocked");

endmodule

// ===== tb/rocof_source.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// frequency tracking and blocking matrix model
// ----------------------------------------------------------------
module rocof_source
   import rocof_pkg::*;
#(
   parameter int MS_CLKS = 100
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // requested values
   input wire meas_t measReq,
   input wire logic blockReq,
   input wire logic [2:0] grpReq,
   // to the stage
   output meas_t meas,
   output logic blockIn,
   output logic [2:0] groupSel,
   output logic [31:0] timeNow
);
   int msCnt;

   // values are presented as clean levels, one clock after request
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meas <= '0;
         blockIn <= 1'b0;
         groupSel <= 3'h0;
      end
      else
      begin
         meas <= measReq;
         blockIn <= blockReq;
         groupSel <= grpReq;
      end
   end

   // millisecond time stamp
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         msCnt <= 0;
         timeNow <= 32'h0;
      end
      else if (msCnt == MS_CLKS - 1)
      begin
         msCnt <= 0;
         timeNow <= timeNow + 32'h1;
      end
      else
         msCnt <= msCnt + 1;
   end
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ps

module tb;
   import rocof_pkg::*;
   localparam int CC = 16;
   logic core_clk = 0;
   logic rst_n = 0;
   meas_t measReq = '0;
   logic blockReq = 0;
   logic [2:0] grpReq = 0;
   meas_t meas;
   logic blockIn;
   logic [2:0] groupSel;
   logic [31:0] timeNow;
   logic [7:0] regAddr = 0;
   logic [31:0] regWrData = 0;
   logic regWr = 0;
   logic regRd = 0;
   logic [31:0] regRdData;
   logic startOut;
   logic tripOut;
   logic blockedOut;
   evt_t evt;
   int errors = 0;
   int num_checks = 0;
   int n;
   logic [31:0] d;
   int tripOn = 0;

   rocof_source src_i (.core_clk(core_clk), .rst_n(rst_n), .measReq(measReq), .blockReq(blockReq),
      .grpReq(grpReq), .meas(meas), .blockIn(blockIn), .groupSel(groupSel), .timeNow(timeNow));
   rocof_stage #(.CYCLE_CLKS(CC)) rocof_stage_i (.core_clk(core_clk), .rst_n(rst_n), .meas(meas),
      .blockIn(blockIn), .groupSel(groupSel), .timeNow(timeNow), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .startOut(startOut), .tripOut(tripOut),
      .blockedOut(blockedOut), .evt(evt));

   initial
   begin
      forever #5 core_clk = ~core_clk;
   end

   // trip-on event pulses seen on the event port
   always @(posedge core_clk)
   begin
      if (evt.flags[1] === 1'b1)
         tripOn <= tripOn + 1;
   end

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task complete_run;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e)
      begin
         errors++;
         $display("BAD %0t got %h expected %h", $time, s, e);
      end
   endtask

   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge core_clk);
      regAddr <= a;
      regWrData <= v;
      regWr <= 1'b1;
      @(posedge core_clk);
      regWr <= 1'b0;
   endtask

   task rd(input logic [7:0] a);
      @(posedge core_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge core_clk);
      regRd <= 1'b0;
      #1 d = regRdData;
   endtask

   task setm(input logic signed [15:0] r, input logic [15:0] f, input logic b);
      @(posedge core_clk);
      measReq <= '{rate: r, freq: f};
      blockReq <= b;
   endtask

   // wait for one output bit, bounded, then compare
   task waitOut(input int b, input logic v, input int lim);
      logic [2:0] o;
      n = 0;
      o = {blockedOut, tripOut, startOut};
      while (o[b] !== v && n < lim)
      begin
         @(posedge core_clk);
         #1 n++;
         o = {blockedOut, tripOut, startOut};
      end
      chk(32'(o[b]), 32'(v));
   endtask

   task idle;
      setm(16'sh0, 16'h1388, 1'b0);
      waitOut(0, 1'b0, 5 * CC);
      waitOut(2, 1'b0, 5 * CC);
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task t_reset;
      rd(8'h84);
      chk(d, 32'(PICK_RST));
      rd(8'h88);
      chk(d, {FHIGH_RST, FLOW_RST});
      rd(8'h80);
      chk(d, 32'h0);
      rd(REG_CTRL);
      chk(d, 32'h6);
      rd(REG_MAXRATE);
      chk(d, 32'(MAXRATE_RST));
      wr(REG_STATUS, 32'h3);
      rd(REG_STATUS);
      chk(d, 32'h0);
      rd(8'h34);
      chk(d, 32'h0);
   endtask

   task t_trip;
      wr(REG_CTRL, 32'h7);
      wr(8'h80, 32'h1);
      wr(8'h8C, 32'h3);
      setm(16'sh14, 16'h1388, 1'b0);
      waitOut(0, 1'b1, 4 * CC);
      waitOut(1, 1'b1, 10 * CC);
      chk(n, 4 * CC);
      rd(REG_STATUS);
      chk(d[1:0], 2'h2);
      chk(tripOn, 32'h1);
      rd(REG_RATE);
      chk(d, 32'h14);
      rd(REG_EXPTIME);
      chk(d, 32'h3);
      rd(REG_RATIO);
      chk(d, 32'd200);
      wr(REG_RECSEL, 32'h1);
      rd(REG_REC_INFO);
      chk(d, 32'h1);
      rd(REG_REC_FLT);
      chk(d, 32'h00141388);
      rd(REG_REC_PRE);
      chk(d, 32'h00141388);
      rd(REG_COUNT);
      chk(d, 32'h2);
      wr(REG_CTRL, 32'hF);
      rd(REG_COUNT);
      chk(d, 32'h0);
   endtask

   task t_hyst;
      idle;
      wr(8'h8C, 32'h40);
      setm(16'sh14, 16'h1388, 1'b0);
      waitOut(0, 1'b1, 4 * CC);
      setm(16'sh0B, 16'h1388, 1'b0);
      repeat (4 * CC) @(posedge core_clk);
      #1 chk(startOut, 1'b1);
      chk(tripOut, 1'b0);
      setm(16'sh0A, 16'h1388, 1'b0);
      waitOut(0, 1'b0, 4 * CC);
   endtask

   task t_fall;
      wr(8'h80, 32'h3);
      setm(16'sh14, 16'h1388, 1'b0);
      repeat (4 * CC) @(posedge core_clk);
      #1 chk(startOut, 1'b0);
      setm(-16'sh14, 16'h1388, 1'b0);
      waitOut(0, 1'b1, 4 * CC);
      rd(REG_RATE);
      chk(d, 32'hFFFFFFEC);
      idle;
      wr(8'h80, 32'h5);
      setm(-16'sh14, 16'h1388, 1'b0);
      waitOut(0, 1'b1, 4 * CC);
      idle;
   endtask

   task t_block;
      wr(REG_CTRL, 32'hF);
      wr(8'h80, 32'h1);
      setm(16'sh14, 16'h1388, 1'b1);
      waitOut(2, 1'b1, 4 * CC);
      chk(startOut, 1'b0);
      rd(REG_COUNT);
      chk(d, 32'h1);
      idle;
      wr(8'h8C, 32'hA);
      setm(16'sh14, 16'h1388, 1'b0);
      waitOut(0, 1'b1, 4 * CC);
      repeat (2 * CC) @(posedge core_clk);
      rd(REG_REMAIN);
      chk(d, 32'h8);
      setm(16'sh14, 16'h1388, 1'b1);
      waitOut(0, 1'b0, 4 * CC);
      repeat (10 * CC) @(posedge core_clk);
      #1 chk(tripOut, 1'b0);
      idle;
   endtask

   task t_lim;
      wr(8'h80, 32'h9);
      wr(8'h8C, 32'h3);
      setm(16'sh14, 16'h1388, 1'b0);
      waitOut(0, 1'b1, 4 * CC);
      repeat (8 * CC) @(posedge core_clk);
      #1 chk(tripOut, 1'b0);
      setm(16'sh14, 16'h1450, 1'b0);
      waitOut(1, 1'b1, 8 * CC);
      idle;
      wr(8'h80, 32'hB);
      setm(-16'sh14, 16'h1388, 1'b0);
      waitOut(0, 1'b1, 4 * CC);
      repeat (8 * CC) @(posedge core_clk);
      #1 chk(tripOut, 1'b0);
      setm(-16'sh14, 16'h1300, 1'b0);
      waitOut(1, 1'b1, 8 * CC);
      idle;
   endtask

   task t_group;
      wr(8'h80, 32'h0);
      wr(8'h90, 32'h1);
      setm(16'sh14, 16'h1388, 1'b0);
      repeat (4 * CC) @(posedge core_clk);
      grpReq <= 3'h1;
      #1 chk(startOut, 1'b0);
      waitOut(0, 1'b1, 4 * CC);
      rd(REG_STATUS);
      chk(d[5:3], 3'h1);
      wr(REG_CTRL, 32'h6);
      waitOut(0, 1'b0, 4 * CC);
      wr(REG_CTRL, 32'h7);
      wr(REG_MAXRATE, 32'h1);
      waitOut(2, 1'b1, 4 * CC);
      chk(startOut, 1'b0);
   endtask

   initial
   begin
      #200000;
      errors++;
      complete_run;
   end

   initial
   begin
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      t_reset;
      t_trip;
      t_hyst;
      t_fall;
      t_block;
      t_lim;
      t_group;
      complete_run;
   end
endmodule
